// ### logic/pt_status_defs.svh
`ifndef PT_STATUS_DEFS_SVH
`define PT_STATUS_DEFS_SVH

`define MSG_ABORT 8'h06
`define MSG_DEV_RESET 8'h0C
`define MSG_CLEAR_QUEUE 8'h0E
`define ERR_NONE 8'h00
`define ERR_INVALID_CMD 8'h01
`define ERR_BAD_PHASE 8'h24
`define STAT_CODE_MASK 8'h3E
`define STAT_GOOD 8'h00
`define STAT_CHECK 8'h02
`define STAT_COND_MET 8'h04
`define STAT_BUSY 8'h08
`define STAT_INTERMED 8'h10
`define STAT_INT_COND_MET 8'h14
`define STAT_RESV_CONFLICT 8'h18
`define STAT_QUEUE_FULL 8'h28
`define LUN_MSB 7
`define LUN_LSB 5
`define BLK_ID_OFF 4'h0
`define BLK_STAT_OFF 4'h4
`define BLK_SENSE0_OFF 4'h8
`define BLK_SENSE1_OFF 4'hC
`define FLAG_DONE 7
`define FLAG_ERR 6
`define FLAG_RETRY 5
`define FLAG_TRUNC 4
`define FLAG_CONT 2
`define SENSE_MAX 9'h100
`define SEQ_MAX 6'h20
`define SEL_NUM 16
`define SEL_SHORT 6'h08
`define SEL_LONG 6'h10
`define DEFAULT_COUNT 6'h08
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SEL0 8'h10
`define CTRL_EXT_BIT 8

`endif

// ### logic/pt_status_pkg.sv
package pt_status_pkg;
	typedef enum logic [3:0] {
		S_IDLE, S_MSG, S_WAIT, S_SENSE, S_WR_ID, S_RD, S_CAP, S_WR_STAT
	} state_t;
	typedef enum logic [2:0] {
		PH_DATA_OUT, PH_DATA_IN, PH_COMMAND, PH_STATUS,
		PH_RESERVED, PH_MSG_OUT, PH_MSG_IN
	} phase_t;
	typedef enum logic [1:0] {
		SM_DEFAULT, SM_SEQ, SM_SEL
	} sense_mode_t;
endpackage

// ### logic/sense_mem.sv
`timescale 1ns/1ps
`default_nettype none
module sense_mem (
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data
);
	logic [7:0] mem [0:255];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ### logic/pt_status_reporter.sv
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pt_status_defs.svh"
module pt_status_reporter
	import pt_status_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic cmd_start,
	input wire logic [31:0] cmd_id,
	input wire logic cmd_msg_only,
	input wire logic [7:0] cmd_msg_code,
	input wire logic [7:0] cmd_lun,
	input wire logic inhibit_auto_sense,
	input wire logic [31:0] cmd_xfer_count,
	input wire logic tgt_done,
	input wire logic [7:0] tgt_status,
	input wire logic [31:0] tgt_bytes_moved,
	input wire logic tgt_retried,
	input wire logic tgt_phase_err,
	input wire logic tgt_msg,
	input wire logic tgt_cd,
	input wire logic tgt_io,
	input wire logic adp_err,
	input wire logic [7:0] adp_err_code,
	input wire logic sense_valid,
	input wire logic [7:0] sense_data,
	input wire logic sense_last,
	output logic msg_issue,
	output logic [7:0] msg_code_out,
	output logic [2:0] msg_lun_out,
	output logic sense_issue,
	output logic busy,
	output logic blk_we,
	output logic [3:0] blk_addr,
	output logic [31:0] blk_wdata,
	output logic blk_done
);
	state_t state_r;
	phase_t phase_r;
	phase_t phase_nxt;
	sense_mode_t mode_r;
	logic [5:0] sense_count_r;
	logic ext_sel_r;
	logic [7:0] sel_r [0:`SEL_NUM-1];
	logic [`SEL_NUM-1:0] sel_nz;
	logic [31:0] id_r;
	logic [31:0] xfer_r;
	logic inhibit_r;
	logic [5:0] nrep_r;
	logic [7:0] stat_r;
	logic [7:0] err_r;
	logic flag_err_r;
	logic rty_r;
	logic dtt_r;
	logic sense_ok_r;
	logic [8:0] rx_cnt_r;
	logic [2:0] nblk_r;
	logic [1:0] blk_idx_r;
	logic [2:0] slot_r;
	logic byte_ok_r;
	logic [31:0] acc_r;
	logic [4:0] slot_j;
	logic [7:0] mem_raddr;
	logic [7:0] mem_rdata;
	logic mem_we;
	logic byte_ok_nxt;
	logic msg_ok;
	logic [7:0] code_m;
	logic status_bad;
	logic [6:0] nblk_sum;

	// Per-entry selected sense byte numbers
	genvar gi;
	generate
		for (gi = 0; gi < `SEL_NUM; gi = gi + 1) begin : g_sel
			localparam logic [7:0] WADDR = `REG_SEL0 + 8'(4 * (gi / 4));
			localparam int LANE = 8 * (gi % 4);
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					sel_r[gi] <= 8'h00;
				end else if (reg_wr && reg_addr == WADDR) begin
					sel_r[gi] <= reg_wdata[LANE +: 8];
				end
			end
			assign sel_nz[gi] = |sel_r[gi];
		end
	endgenerate

	// Control register
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sense_count_r <= 6'h00;
			ext_sel_r <= 1'b0;
		end else if (reg_wr && reg_addr == `REG_CTRL) begin
			if (reg_wdata[5:0] > `SEQ_MAX) begin
				sense_count_r <= `SEQ_MAX;
			end else begin
				sense_count_r <= reg_wdata[5:0];
			end
			ext_sel_r <= reg_wdata[`CTRL_EXT_BIT];
		end
	end

	// Register read port
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`REG_CTRL: reg_rdata <= {23'h00_0000, ext_sel_r, 2'b00,
					sense_count_r};
				`REG_STATUS: reg_rdata <= {err_r, stat_r, rx_cnt_r,
					3'(phase_r), phase_r == PH_RESERVED, sense_ok_r,
					flag_err_r, busy};
				`REG_SEL0: reg_rdata <= {sel_r[3], sel_r[2], sel_r[1],
					sel_r[0]};
				`REG_SEL0 + 8'h04: reg_rdata <= {sel_r[7], sel_r[6],
					sel_r[5], sel_r[4]};
				`REG_SEL0 + 8'h08: reg_rdata <= {sel_r[11], sel_r[10],
					sel_r[9], sel_r[8]};
				`REG_SEL0 + 8'h0C: reg_rdata <= {sel_r[15], sel_r[14],
					sel_r[13], sel_r[12]};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Decode helpers
	always_comb begin
		msg_ok = cmd_msg_code == `MSG_ABORT ||
			cmd_msg_code == `MSG_DEV_RESET ||
			cmd_msg_code == `MSG_CLEAR_QUEUE;
		code_m = tgt_status & `STAT_CODE_MASK;
		case (code_m)
			`STAT_GOOD, `STAT_COND_MET, `STAT_INTERMED,
			`STAT_INT_COND_MET: status_bad = 1'b0;
			default: status_bad = 1'b1;
		endcase
		case ({tgt_msg, tgt_cd, tgt_io})
			3'b000: phase_nxt = PH_DATA_OUT;
			3'b001: phase_nxt = PH_DATA_IN;
			3'b010: phase_nxt = PH_COMMAND;
			3'b011: phase_nxt = PH_STATUS;
			3'b110: phase_nxt = PH_MSG_OUT;
			3'b111: phase_nxt = PH_MSG_IN;
			default: phase_nxt = PH_RESERVED;
		endcase
	end

	// Sense slot to byte number
	always_comb begin
		slot_j = {blk_idx_r, slot_r};
		if (mode_r == SM_SEL) begin
			mem_raddr = sel_r[slot_j[3:0]];
		end else begin
			mem_raddr = {3'b000, slot_j};
		end
		byte_ok_nxt = sense_ok_r && {1'b0, slot_j} < nrep_r &&
			{1'b0, mem_raddr} < rx_cnt_r;
		nblk_sum = {1'b0, nrep_r} + 7'h07;
	end

	assign mem_we = state_r == S_SENSE && sense_valid &&
		rx_cnt_r != `SENSE_MAX;

	sense_mem u_sense_mem (
		.sys_clk(sys_clk),
		.wr_en(mem_we),
		.wr_addr(rx_cnt_r[7:0]),
		.wr_data(sense_data),
		.rd_addr(mem_raddr),
		.rd_data(mem_rdata)
	);

	// Sense byte capture count
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rx_cnt_r <= 9'h000;
		end else if (state_r == S_IDLE && cmd_start) begin
			rx_cnt_r <= 9'h000;
		end else if (mem_we) begin
			rx_cnt_r <= rx_cnt_r + 9'h001;
		end
	end

	// Command capture and result fields
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			id_r <= 32'h0000_0000;
			xfer_r <= 32'h0000_0000;
			inhibit_r <= 1'b0;
			mode_r <= SM_DEFAULT;
			nrep_r <= `DEFAULT_COUNT;
			stat_r <= 8'h00;
			err_r <= `ERR_NONE;
			flag_err_r <= 1'b0;
			rty_r <= 1'b0;
			dtt_r <= 1'b0;
			sense_ok_r <= 1'b0;
			phase_r <= PH_DATA_OUT;
		end else if (state_r == S_IDLE && cmd_start) begin
			id_r <= cmd_id;
			xfer_r <= cmd_xfer_count;
			inhibit_r <= inhibit_auto_sense;
			stat_r <= 8'h00;
			rty_r <= 1'b0;
			dtt_r <= 1'b0;
			sense_ok_r <= 1'b0;
			if (sense_count_r != 6'h00) begin
				mode_r <= SM_SEQ;
				nrep_r <= sense_count_r;
			end else if (|sel_nz) begin
				mode_r <= SM_SEL;
				nrep_r <= ext_sel_r ? `SEL_LONG : `SEL_SHORT;
			end else begin
				mode_r <= SM_DEFAULT;
				nrep_r <= `DEFAULT_COUNT;
			end
			if (cmd_msg_only && !msg_ok) begin
				err_r <= `ERR_INVALID_CMD;
				flag_err_r <= 1'b1;
			end else begin
				err_r <= `ERR_NONE;
				flag_err_r <= 1'b0;
			end
		end else if (state_r == S_MSG || state_r == S_WAIT) begin
			if (adp_err) begin
				err_r <= adp_err_code;
				flag_err_r <= 1'b1;
			end else if (tgt_phase_err) begin
				err_r <= `ERR_BAD_PHASE;
				stat_r <= {5'b00000, tgt_msg, tgt_cd, tgt_io};
				phase_r <= phase_nxt;
				flag_err_r <= 1'b1;
			end else if (tgt_done) begin
				stat_r <= tgt_status;
				flag_err_r <= status_bad;
				rty_r <= tgt_retried;
				dtt_r <= xfer_r != 32'h0000_0000 &&
					tgt_bytes_moved < xfer_r;
				sense_ok_r <= state_r == S_WAIT &&
					code_m == `STAT_CHECK && !inhibit_r;
			end
		end
	end

	// Sequencer
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= S_IDLE;
			busy <= 1'b0;
			msg_issue <= 1'b0;
			msg_code_out <= 8'h00;
			msg_lun_out <= 3'b000;
			sense_issue <= 1'b0;
			blk_we <= 1'b0;
			blk_addr <= `BLK_ID_OFF;
			blk_wdata <= 32'h0000_0000;
			blk_done <= 1'b0;
			nblk_r <= 3'b001;
			blk_idx_r <= 2'b00;
			slot_r <= 3'b000;
			byte_ok_r <= 1'b0;
			acc_r <= 32'h0000_0000;
		end else begin
			msg_issue <= 1'b0;
			sense_issue <= 1'b0;
			blk_we <= 1'b0;
			blk_done <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (cmd_start) begin
						busy <= 1'b1;
						blk_we <= 1'b1;
						blk_addr <= `BLK_STAT_OFF;
						blk_wdata <= 32'h0000_0000;
						blk_idx_r <= 2'b00;
						slot_r <= 3'b000;
						nblk_r <= 3'b001;
						if (!cmd_msg_only) begin
							state_r <= S_WAIT;
						end else if (msg_ok) begin
							msg_issue <= 1'b1;
							msg_code_out <= cmd_msg_code;
							msg_lun_out <= cmd_lun[`LUN_MSB:`LUN_LSB];
							state_r <= S_MSG;
						end else begin
							state_r <= S_WR_ID;
						end
					end
				end
				S_MSG: begin
					if (adp_err || tgt_phase_err || tgt_done) begin
						state_r <= S_WR_ID;
					end
				end
				S_WAIT: begin
					if (adp_err || tgt_phase_err) begin
						state_r <= S_WR_ID;
					end else if (tgt_done) begin
						if (code_m == `STAT_CHECK && !inhibit_r) begin
							sense_issue <= 1'b1;
							state_r <= S_SENSE;
						end else begin
							state_r <= S_WR_ID;
						end
					end
				end
				S_SENSE: begin
					if (sense_valid && sense_last) begin
						nblk_r <= nblk_sum[5:3];
						state_r <= S_WR_ID;
					end
				end
				S_WR_ID: begin
					blk_we <= 1'b1;
					blk_addr <= `BLK_ID_OFF;
					blk_wdata <= id_r;
					state_r <= S_RD;
				end
				S_RD: begin
					byte_ok_r <= byte_ok_nxt;
					state_r <= S_CAP;
				end
				S_CAP: begin
					acc_r <= {acc_r[23:0],
						byte_ok_r ? mem_rdata : 8'h00};
					slot_r <= slot_r + 3'b001;
					if (slot_r[1:0] == 2'b11) begin
						blk_we <= 1'b1;
						blk_addr <= slot_r[2] ? `BLK_SENSE1_OFF :
							`BLK_SENSE0_OFF;
						blk_wdata <= {acc_r[23:0],
							byte_ok_r ? mem_rdata : 8'h00};
					end
					state_r <= slot_r == 3'b111 ? S_WR_STAT : S_RD;
				end
				S_WR_STAT: begin
					blk_we <= 1'b1;
					blk_addr <= `BLK_STAT_OFF;
					blk_wdata <= {8'h00, stat_r, err_r, 8'h00};
					blk_wdata[`FLAG_DONE] <= 1'b1;
					blk_wdata[`FLAG_ERR] <= flag_err_r;
					blk_wdata[`FLAG_RETRY] <= rty_r;
					blk_wdata[`FLAG_TRUNC] <= dtt_r;
					blk_wdata[`FLAG_CONT] <= blk_idx_r != 2'b00;
					blk_done <= 1'b1;
					if (sense_ok_r && {1'b0, blk_idx_r} + 3'b001 < nblk_r) begin
						blk_idx_r <= blk_idx_r + 2'b01;
						state_r <= S_WR_ID;
					end else begin
						busy <= 1'b0;
						state_r <= S_IDLE;
					end
				end
				default: begin
					busy <= 1'b0;
					state_r <= S_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ### tb/pt_status_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pt_status_sva
	import pt_status_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic cmd_start,
	input wire logic cmd_msg_only,
	input wire logic [7:0] cmd_msg_code,
	input wire logic inhibit_auto_sense,
	input wire logic tgt_done,
	input wire logic [7:0] tgt_status,
	input wire logic tgt_phase_err,
	input wire logic tgt_msg,
	input wire logic tgt_cd,
	input wire logic tgt_io,
	input wire logic adp_err,
	input wire logic msg_issue,
	input wire logic sense_issue,
	input wire logic busy,
	input wire logic blk_we,
	input wire logic [3:0] blk_addr,
	input wire logic [31:0] blk_wdata,
	input wire logic blk_done
);
	logic [7:0] st_r;
	logic [2:0] ph_r;
	logic td_r, pe_r, ih_r, mo_r;
	wire logic go = cmd_start && !busy;
	wire logic ev = busy && !adp_err;
	wire logic okm = cmd_msg_code inside {8'h06, 8'h0C, 8'h0E};
	// Last result event of the command
	always_ff @(posedge sys_clk) begin
		if (reset || go) begin
			td_r <= 1'b0;
			pe_r <= 1'b0;
			ih_r <= inhibit_auto_sense;
			mo_r <= cmd_msg_only;
		end else if (ev && tgt_phase_err) begin
			pe_r <= 1'b1;
			ph_r <= {tgt_msg, tgt_cd, tgt_io};
		end else if (ev && tgt_done) begin
			td_r <= 1'b1;
			st_r <= tgt_status;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	property p_msg_ok;
		go && cmd_msg_only && okm |=> msg_issue;
	endproperty
	a_msg_ok: assert property (p_msg_ok)
		else $error("valid message not issued");
	property p_msg_bad;
		go && cmd_msg_only && !okm |=> !msg_issue ##[1:60]
			(blk_done && blk_wdata[15:8] == 8'h01 && blk_wdata[6]);
	endproperty
	a_msg_bad: assert property (p_msg_bad)
		else $error("invalid message not refused");
	property p_open;
		go |=> blk_we && blk_addr == 4'h4 && blk_wdata == '0 && busy;
	endproperty
	a_open: assert property (p_open)
		else $error("opening status word wrong");
	property p_done;
		blk_done |-> blk_we && blk_addr == 4'h4 && blk_wdata[7] &&
			$past(blk_we) && $past(blk_addr) == 4'hC;
	endproperty
	a_done: assert property (p_done)
		else $error("completion written out of order");
	property p_sense;
		tgt_done && ev && !tgt_phase_err && tgt_status == 8'h02 &&
			!ih_r && !mo_r |=> sense_issue;
	endproperty
	a_sense: assert property (p_sense)
		else $error("sense request missing");
	property p_nosense;
		tgt_done && ev && (tgt_status != 8'h02 || ih_r ||
			mo_r) |=> !sense_issue;
	endproperty
	a_nosense: assert property (p_nosense)
		else $error("sense request unwanted");
	property p_stat;
		blk_done && td_r && !pe_r |-> blk_wdata[23:16] == st_r;
	endproperty
	a_stat: assert property (p_stat)
		else $error("status byte not copied");
	property p_phase;
		blk_done && pe_r |-> blk_wdata[15:8] == 8'h24 &&
			blk_wdata[18:16] == ph_r && blk_wdata[6];
	endproperty
	a_phase: assert property (p_phase)
		else $error("phase error report wrong");
	c_sense: cover property (sense_issue);
	c_phase: cover property (blk_done && pe_r);
	c_cont: cover property (blk_done && blk_wdata[2]);
endmodule
bind pt_status_reporter pt_status_sva u_sva (.sys_clk, .reset, .cmd_start,
	.cmd_msg_only, .cmd_msg_code, .inhibit_auto_sense, .tgt_done,
	.tgt_status, .tgt_phase_err, .tgt_msg, .tgt_cd, .tgt_io, .adp_err,
	.msg_issue, .sense_issue, .busy, .blk_we, .blk_addr, .blk_wdata,
	.blk_done);
`default_nettype wire

// ### tb/scsi_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module scsi_target_model (
	input wire logic sys_clk,
	input wire logic sense_issue,
	input wire logic [8:0] sense_len,
	output logic sense_valid,
	output logic [7:0] sense_data,
	output logic sense_last
);
	int n;
	initial begin
		sense_valid = 1'b0;
		sense_data = 8'h00;
		sense_last = 1'b0;
		forever begin
			@(posedge sys_clk);
			if (sense_issue) begin
				// Sense stream, one byte every other cycle
				for (n = 0; n < sense_len; n++) begin
					@(posedge sys_clk);
					sense_valid <= 1'b1;
					sense_data <= 8'(n + 8'h30);
					sense_last <= (n == sense_len - 1);
					@(posedge sys_clk);
					sense_valid <= 1'b0;
					sense_last <= 1'b0;
					sense_data <= ~sense_data;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/scsi_passthru_status_reporter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module scsi_passthru_status_reporter_tb_top;
	logic sys_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic cmd_start = 1'b0, cmd_msg_only = 1'b0, inhibit_auto_sense = 1'b0;
	logic tgt_done = 1'b0, tgt_retried = 1'b0, tgt_phase_err = 1'b0;
	logic tgt_msg = 1'b0, tgt_cd = 1'b0, tgt_io = 1'b0, adp_err = 1'b0;
	logic [7:0] reg_addr = '0, cmd_msg_code = '0, cmd_lun = '0;
	logic [7:0] tgt_status = '0, adp_err_code = '0, sense_data, msg_code_out;
	logic [31:0] reg_wdata = '0, cmd_id = '0, cmd_xfer_count = '0;
	logic [31:0] tgt_bytes_moved = '0, reg_rdata, blk_wdata;
	logic [2:0] msg_lun_out;
	logic [3:0] blk_addr;
	logic sense_valid, sense_last, msg_issue, sense_issue, busy;
	logic blk_we, blk_done;
	logic [8:0] slen = 9'h028;
	logic [7:0] sel[16], aec = 8'h00;
	logic sm = 1'b0;
	logic [35:0] wq[$];
	logic [7:0] mcs[5] = '{8'h06, 8'h0C, 8'h0E, 8'h05, 8'h0F};
	logic [7:0] scs[8] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h10, 8'h14,
		8'h18, 8'h28};
	int failures = 0, compares = 0;
	pt_status_reporter u_dut (.sys_clk, .reset, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .cmd_start, .cmd_id, .cmd_msg_only,
		.cmd_msg_code, .cmd_lun, .inhibit_auto_sense, .cmd_xfer_count,
		.tgt_done, .tgt_status, .tgt_bytes_moved, .tgt_retried,
		.tgt_phase_err, .tgt_msg, .tgt_cd, .tgt_io, .adp_err, .adp_err_code,
		.sense_valid, .sense_data, .sense_last, .msg_issue, .msg_code_out,
		.msg_lun_out, .sense_issue, .busy, .blk_we, .blk_addr, .blk_wdata,
		.blk_done);
	scsi_target_model u_tgt (.sys_clk, .sense_issue, .sense_len(slen),
		.sense_valid, .sense_data, .sense_last);
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (blk_we) wq.push_back({blk_addr, blk_wdata});
	task chk(input logic [35:0] s, e);
		compares++;
		if (s !== e) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task finish_test;
		$display("failures=%0d compares=%0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task reg_op(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask
	function automatic logic [7:0] sb(input int i, input logic on);
		int j;
		j = sm ? int'(sel[i]) : i;
		return (on && j < slen) ? 8'(j + 8'h30) : 8'h00;
	endfunction
	function automatic logic [31:0] sw(input int i, input logic on);
		return {sb(i, on), sb(i + 1, on), sb(i + 2, on), sb(i + 3, on)};
	endfunction
	task run(input logic mo, input logic [7:0] mc, st, input logic inh, pe,
		input int nb);
		logic [7:0] ec, sf;
		logic [31:0] xc, mv, id;
		logic [2:0] ph, ln;
		logic ry, on, e, bad, transfer_truncated_flag, ab;
		int n;
		ab = aec != 8'h00;
		bad = mo && !(mc inside {8'h06, 8'h0C, 8'h0E});
		xc = (mo || pe || ab) ? '0 : $urandom_range(0, 9);
		mv = $urandom_range(0, 9);
		ry = !(mo || pe || ab) && $urandom_range(0, 1);
		id = $urandom;
		ph = 3'($urandom);
		ln = 3'($urandom);
		ec = ab ? aec : pe ? 8'h24 : bad ? 8'h01 : 8'h00;
		sf = ab ? 8'h00 : pe ? {5'h00, ph} : bad ? 8'h00 : st;
		on = !mo && !pe && !ab && st == 8'h02 && !inh;
		e = ec != 8'h00 || !(st inside {8'h00, 8'h04, 8'h10, 8'h14});
		transfer_truncated_flag = xc != '0 && mv < xc;
		wq.delete();
		@(posedge sys_clk);
		cmd_start <= 1'b1;
		cmd_id <= id;
		cmd_msg_only <= mo;
		cmd_msg_code <= mc;
		cmd_lun <= {ln, 5'h00};
		inhibit_auto_sense <= inh;
		cmd_xfer_count <= xc;
		{tgt_msg, tgt_cd, tgt_io} <= ph;
		@(posedge sys_clk);
		cmd_start <= 1'b0;
		repeat (3) @(posedge sys_clk);
		tgt_done <= !pe && !bad;
		tgt_phase_err <= pe;
		adp_err <= ab;
		adp_err_code <= aec;
		tgt_status <= st;
		tgt_bytes_moved <= mv;
		tgt_retried <= ry;
		@(posedge sys_clk);
		tgt_done <= 1'b0;
		tgt_phase_err <= 1'b0;
		adp_err <= 1'b0;
		for (n = 0; n < 3000 && busy !== 1'b0; n++) @(posedge sys_clk);
		#1;
		chk(busy, 1'b0);
		chk(wq.size(), 1 + 4 * nb);
		if (wq.size() == 1 + 4 * nb) begin
			chk(wq[0], {4'h4, 32'h0000_0000});
			for (int b = 0; b < nb; b++) begin
				chk(wq[4 * b + 1], {4'h0, id});
				chk(wq[4 * b + 2], {4'h8, sw(8 * b, on)});
				chk(wq[4 * b + 3], {4'hC, sw(8 * b + 4, on)});
				chk(wq[4 * b + 4], {4'h4, 8'h00, sf, ec, 1'b1, e, ry, transfer_truncated_flag,
					1'b0, b != 0, 2'b00});
			end
		end
		if (mo && !bad) begin
			chk(msg_code_out, mc);
			chk(msg_lun_out, ln);
		end
	endtask
	initial begin
		void'($urandom(32'h20f1));
		repeat (4) @(posedge sys_clk);
		reset <= 1'b0;
		reg_op(1'b0, 8'h40, '0);
		chk(reg_rdata, '0);
		reg_op(1'b1, 8'h00, '0);
		foreach (mcs[i]) run(1'b1, mcs[i], 8'h00, 1'b0, 1'b0, 1);
		foreach (scs[i]) run(1'b0, 8'h00, scs[i], 1'b0, 1'b0, 1);
		run(1'b0, 8'h00, 8'h02, 1'b1, 1'b0, 1);
		repeat (3) run(1'b0, 8'h00, 8'h02, 1'b0, 1'b1, 1);
		aec = 8'($urandom_range(128, 255));
		run(1'b0, 8'h00, 8'h02, 1'b0, 1'b0, 1);
		aec = 8'h00;
		foreach (sel[k]) sel[k] = 8'($urandom_range(1, 63));
		for (int k = 0; k < 4; k++) reg_op(1'b1, 8'h10 + 8'(4 * k),
			{sel[4 * k + 3], sel[4 * k + 2], sel[4 * k + 1], sel[4 * k]});
		reg_op(1'b0, 8'h1C, '0);
		chk(reg_rdata, {sel[15], sel[14], sel[13], sel[12]});
		sm = 1'b1;
		reg_op(1'b1, 8'h00, 32'h0000_0100);
		run(1'b0, 8'h00, 8'h02, 1'b0, 1'b0, 2);
		reg_op(1'b1, 8'h00, 32'h0000_0000);
		run(1'b0, 8'h00, 8'h02, 1'b0, 1'b0, 1);
		sm = 1'b0;
		reg_op(1'b1, 8'h00, 32'h0000_0010);
		run(1'b0, 8'h00, 8'h02, 1'b0, 1'b0, 2);
		slen = 9'h100;
		reg_op(1'b1, 8'h00, 32'h0000_0028);
		reg_op(1'b0, 8'h00, '0);
		chk(reg_rdata, 32'h0000_0020);
		run(1'b0, 8'h00, 8'h02, 1'b0, 1'b0, 4);
		finish_test;
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		failures++;
		finish_test;
	end
endmodule
`default_nettype wire
